// ### hw/memory_boundary_scan_tap.sv
// Boundary-scan test access port of a synchronous memory
// Operation
// - 3-bit instruction, 1-bit bypass, 32-bit ID, 109-cell chain.
// - Code 000: chain drives output balls, captures input balls.
// - Update-IR loading EXTEST enables drivers with preloaded chain data.
// - Code 001: capture ID value, shift ID register.
// - Instruction resets to IDCODE at power-up and Test-Logic-Reset.
// - Code 010: outputs high-Z, capture inputs, shift chain.
// - Code 100: capture inputs and I/O buffers, shift chain.
// - Code 111: bypass cell sits between data in and out.
// - Termination off under EXTEST, high-Z sample or SAMPLE.
// - After EXTEST normal operation returns only after power-up.
// - Five TMS-high edges or power-up enter Test-Logic-Reset.
// - Inputs sampled on rising, serial output changes on falling edge.
`timescale 1ns/1ps
`default_nettype none
module memory_boundary_scan_tap #(
  parameter int CHAIN = 109
) (
  // Clock and power-up reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // Test pins
  input  wire logic             tck,
  input  wire logic             tms,
  input  wire logic             tdi,
  output logic                  tdo,
  output logic                  tdo_oe,
  // Memory pin view
  input  wire logic [CHAIN-1:0] pin_in,
  output logic [CHAIN-1:0]      pin_drive,
  output logic                  pin_drive_en,
  output logic                  outputs_hiz,
  output logic                  on_die_termination,
  output logic                  normal_mode_lost,
  // Drained snapshot stream
  output logic                  snap_valid,
  input  wire logic             snap_ready,
  output logic [CHAIN-1:0]      snap_data
);
  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic       tck_d_r;
  logic       rise;
  logic       fall;
  logic       tms_s;
  logic       tdi_s;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      tck_d_r <= 1'b0;
    end
    else
    begin
      sync1_r <= {tck, tms, tdi};
      sync2_r <= sync1_r;
      tck_d_r <= sync2_r[2];
    end
  end

  assign tms_s = sync2_r[1];
  assign tdi_s = sync2_r[0];
  assign rise  = sync2_r[2] && !tck_d_r;
  assign fall  = !sync2_r[2] && tck_d_r;

  // ------------------------------------------------------------
  // Controller
  // ------------------------------------------------------------
  scan_tap_pkg::tap_state_type state_r;
  scan_tap_pkg::tap_state_type state_nxt;
  logic [2:0] tms_run_r;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      scan_tap_pkg::TLR:    state_nxt = tms_s ? scan_tap_pkg::TLR    : scan_tap_pkg::RTI;
      scan_tap_pkg::RTI:    state_nxt = tms_s ? scan_tap_pkg::SEL_DR : scan_tap_pkg::RTI;
      scan_tap_pkg::SEL_DR: state_nxt = tms_s ? scan_tap_pkg::SEL_IR : scan_tap_pkg::CAP_DR;
      scan_tap_pkg::CAP_DR: state_nxt = tms_s ? scan_tap_pkg::EX1_DR : scan_tap_pkg::SH_DR;
      scan_tap_pkg::SH_DR:  state_nxt = tms_s ? scan_tap_pkg::EX1_DR : scan_tap_pkg::SH_DR;
      scan_tap_pkg::EX1_DR: state_nxt = tms_s ? scan_tap_pkg::UPD_DR : scan_tap_pkg::PA_DR;
      scan_tap_pkg::PA_DR:  state_nxt = tms_s ? scan_tap_pkg::EX2_DR : scan_tap_pkg::PA_DR;
      scan_tap_pkg::EX2_DR: state_nxt = tms_s ? scan_tap_pkg::UPD_DR : scan_tap_pkg::SH_DR;
      scan_tap_pkg::UPD_DR: state_nxt = tms_s ? scan_tap_pkg::SEL_DR : scan_tap_pkg::RTI;
      scan_tap_pkg::SEL_IR: state_nxt = tms_s ? scan_tap_pkg::TLR    : scan_tap_pkg::CAP_IR;
      scan_tap_pkg::CAP_IR: state_nxt = tms_s ? scan_tap_pkg::EX1_IR : scan_tap_pkg::SH_IR;
      scan_tap_pkg::SH_IR:  state_nxt = tms_s ? scan_tap_pkg::EX1_IR : scan_tap_pkg::SH_IR;
      scan_tap_pkg::EX1_IR: state_nxt = tms_s ? scan_tap_pkg::UPD_IR : scan_tap_pkg::PA_IR;
      scan_tap_pkg::PA_IR:  state_nxt = tms_s ? scan_tap_pkg::EX2_IR : scan_tap_pkg::PA_IR;
      scan_tap_pkg::EX2_IR: state_nxt = tms_s ? scan_tap_pkg::UPD_IR : scan_tap_pkg::SH_IR;
      scan_tap_pkg::UPD_IR: state_nxt = tms_s ? scan_tap_pkg::SEL_DR : scan_tap_pkg::RTI;
      default:              state_nxt = scan_tap_pkg::TLR;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      state_r <= scan_tap_pkg::TLR;
    else if (rise)
      state_r <= state_nxt;
  end

  // Counts TMS-high edges; only an observer for the forced-reset check
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      tms_run_r <= '0;
    else if (rise)
      tms_run_r <= !tms_s ? 3'h0
                 : (tms_run_r == 3'(scan_tap_pkg::TLR_EDGES)) ? tms_run_r : tms_run_r + 3'h1;
  end

  // ------------------------------------------------------------
  // Instruction path
  // ------------------------------------------------------------
  logic [scan_tap_pkg::IR_WIDTH-1:0] ir_shift_r;
  logic [scan_tap_pkg::IR_WIDTH-1:0] instruction_reg_r;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ir_shift_r        <= scan_tap_pkg::IR_CAPTURE;
      instruction_reg_r <= scan_tap_pkg::IR_RESET;
    end
    else if (rise)
    begin
      case (state_r)
        scan_tap_pkg::TLR:    instruction_reg_r <= scan_tap_pkg::IR_RESET;
        scan_tap_pkg::CAP_IR: ir_shift_r <= scan_tap_pkg::IR_CAPTURE;
        scan_tap_pkg::SH_IR:  ir_shift_r <= {tdi_s, ir_shift_r[2:1]};
        scan_tap_pkg::UPD_IR: instruction_reg_r <= ir_shift_r;
        default:              ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Data registers
  // ------------------------------------------------------------
  logic                                bypass_cell_r;
  logic [scan_tap_pkg::ID_WIDTH-1:0]   device_code_register_r;
  logic [CHAIN-1:0]                    scan_chain_r;
  logic [CHAIN-1:0]                    update_r;
  logic                                uses_chain;
  logic                                chain_capture;

  // Chain bit 0 holds cell 1
  assign uses_chain = (instruction_reg_r == scan_tap_pkg::INS_EXTEST)
                   || (instruction_reg_r == scan_tap_pkg::INS_HIZ_SAMP)
                   || (instruction_reg_r == scan_tap_pkg::INS_SAMPLE);
  assign chain_capture = rise && (state_r == scan_tap_pkg::CAP_DR) && uses_chain;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bypass_cell_r          <= 1'b0;
      device_code_register_r <= '0;
      scan_chain_r           <= '0;
    end
    else if (rise && state_r == scan_tap_pkg::CAP_DR)
    begin
      bypass_cell_r <= 1'b0;
      if (instruction_reg_r == scan_tap_pkg::INS_IDCODE)
        device_code_register_r <= scan_tap_pkg::ID_VALUE;
      // Pin bus may be mid-transition; a garbled sample is harmless
      if (uses_chain)
        scan_chain_r <= pin_in;
    end
    else if (rise && state_r == scan_tap_pkg::SH_DR)
    begin
      case (instruction_reg_r)
        scan_tap_pkg::INS_IDCODE:
          device_code_register_r <= {tdi_s, device_code_register_r[31:1]};
        scan_tap_pkg::INS_EXTEST, scan_tap_pkg::INS_HIZ_SAMP, scan_tap_pkg::INS_SAMPLE:
          scan_chain_r <= {tdi_s, scan_chain_r[CHAIN-1:1]};
        default:
          bypass_cell_r <= tdi_s;
      endcase
    end
  end

  // Update latch feeds the output balls
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      update_r <= '0;
    else if (rise && state_r == scan_tap_pkg::UPD_DR && uses_chain)
      update_r <= scan_chain_r;
  end

  // ------------------------------------------------------------
  // Serial output, changes on falling edge
  // ------------------------------------------------------------
  logic tdo_nxt;
  logic shifting;

  assign shifting = (state_r == scan_tap_pkg::SH_DR) || (state_r == scan_tap_pkg::SH_IR);

  always_comb
  begin
    if (state_r == scan_tap_pkg::SH_IR)
      tdo_nxt = ir_shift_r[0];
    else
      case (instruction_reg_r)
        scan_tap_pkg::INS_IDCODE: tdo_nxt = device_code_register_r[0];
        scan_tap_pkg::INS_EXTEST, scan_tap_pkg::INS_HIZ_SAMP, scan_tap_pkg::INS_SAMPLE:
          tdo_nxt = scan_chain_r[0];
        default:                  tdo_nxt = bypass_cell_r;
      endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else if (fall)
    begin
      tdo    <= tdo_nxt;
      tdo_oe <= shifting;
    end
  end

  // ------------------------------------------------------------
  // Pin control
  // ------------------------------------------------------------
  logic extest_on;
  logic extest_seen_r;

  assign extest_on = (instruction_reg_r == scan_tap_pkg::INS_EXTEST);

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_drive          <= '0;
      pin_drive_en       <= 1'b0;
      outputs_hiz        <= 1'b0;
      on_die_termination <= 1'b1;
    end
    else
    begin
      pin_drive          <= update_r;
      pin_drive_en       <= extest_on;
      outputs_hiz        <= (instruction_reg_r == scan_tap_pkg::INS_HIZ_SAMP);
      on_die_termination <= !uses_chain;
    end
  end

  // Sticky until power-up reset
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      extest_seen_r <= 1'b0;
    else if (extest_on)
      extest_seen_r <= 1'b1;
  end
  assign normal_mode_lost = extest_seen_r;

  // ------------------------------------------------------------
  // Snapshot buffer
  // ------------------------------------------------------------
  pin_fifo #(.WIDTH(CHAIN), .DEPTH(scan_tap_pkg::FIFO_DEPTH)) u_fifo (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .in_valid  (chain_capture),
    .in_ready  (),
    .in_data   (pin_in),
    .out_valid (snap_valid),
    .out_ready (snap_ready),
    .out_data  (snap_data)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_tlr_five;
    @(posedge sys_clk) disable iff (!reset_n)
    (tms_run_r == 3'(scan_tap_pkg::TLR_EDGES)) |-> (state_r == scan_tap_pkg::TLR);
  endproperty
  a_tlr_five: assert property (p_tlr_five) else $error("no reset after five tms");

  property p_ir_default;
    @(posedge sys_clk) disable iff (!reset_n)
    (rise && state_r == scan_tap_pkg::TLR) |=> (instruction_reg_r == scan_tap_pkg::INS_IDCODE);
  endproperty
  a_ir_default: assert property (p_ir_default) else $error("ir not idcode");

  property p_odt;
    @(posedge sys_clk) disable iff (!reset_n)
    uses_chain ##1 uses_chain |-> !on_die_termination;
  endproperty
  a_odt: assert property (p_odt) else $error("termination on in test");

  property p_drive;
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(extest_on) |=> pin_drive_en && pin_drive == $past(update_r);
  endproperty
  a_drive: assert property (p_drive) else $error("extest not driving");

  property p_hiz;
    @(posedge sys_clk) disable iff (!reset_n)
    (instruction_reg_r == scan_tap_pkg::INS_HIZ_SAMP) |=> outputs_hiz && !pin_drive_en;
  endproperty
  a_hiz: assert property (p_hiz) else $error("outputs not high-z");

  property p_id_cap;
    @(posedge sys_clk) disable iff (!reset_n)
    (rise && state_r == scan_tap_pkg::CAP_DR && instruction_reg_r == scan_tap_pkg::INS_IDCODE)
      |=> device_code_register_r == scan_tap_pkg::ID_VALUE;
  endproperty
  a_id_cap: assert property (p_id_cap) else $error("id not captured");

  property p_chain_cap;
    @(posedge sys_clk) disable iff (!reset_n)
    chain_capture |=> scan_chain_r == $past(pin_in);
  endproperty
  a_chain_cap: assert property (p_chain_cap) else $error("chain capture wrong");

  property p_bypass;
    @(posedge sys_clk) disable iff (!reset_n)
    (rise && state_r == scan_tap_pkg::SH_DR && instruction_reg_r == scan_tap_pkg::INS_BYPASS)
      |=> bypass_cell_r == $past(tdi_s);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not loaded");

  property p_tdo_fall;
    @(posedge sys_clk) disable iff (!reset_n)
    !fall |=> $stable(tdo);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off falling edge");

  property p_sticky;
    @(posedge sys_clk) disable iff (!reset_n)
    normal_mode_lost |=> normal_mode_lost;
  endproperty
  a_sticky: assert property (p_sticky) else $error("extest flag cleared");
endmodule // memory_boundary_scan_tap
`default_nettype wire

// ### hw/pin_fifo.sv
// Synchronous FIFO buffering captured pin snapshots
`timescale 1ns/1ps
`default_nettype none
module pin_fifo #(
  parameter int WIDTH = 109,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_r];

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wr_ptr_r] <= in_data;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // pin_fifo
`default_nettype wire

// ### hw/scan_tap_pkg.sv
// Shared constants for the memory boundary-scan test port
package scan_tap_pkg;
  localparam int IR_WIDTH    = 3;
  localparam int ID_WIDTH    = 32;
  localparam int CHAIN_LEN   = 109;
  localparam int SYNC_STAGES = 2;
  // Instruction codes
  localparam logic [2:0] INS_EXTEST   = 3'h0;
  localparam logic [2:0] INS_IDCODE   = 3'h1;
  localparam logic [2:0] INS_HIZ_SAMP = 3'h2;
  localparam logic [2:0] INS_SAMPLE   = 3'h4;
  localparam logic [2:0] INS_BYPASS   = 3'h7;
  // Reset value of the instruction register
  localparam logic [2:0] IR_RESET     = 3'h1;
  // Shift-IR capture pattern (low two bits 01)
  localparam logic [2:0] IR_CAPTURE   = 3'h1;
  // Identification value, arbitrary
  localparam logic [31:0] ID_VALUE    = 32'h1234_5679;
  // FIFO shape on the captured-pin path
  localparam int FIFO_WIDTH = 109;
  localparam int FIFO_DEPTH = 32;
  // TMS-high edges that force Test-Logic-Reset
  localparam int TLR_EDGES  = 5;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } tap_state_type;
endpackage : scan_tap_pkg

// ### test/memory_boundary_scan_tap_tb.sv
// Self-checking bench for the memory boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
module memory_boundary_scan_tap_tb;
  localparam int W     = scan_tap_pkg::CHAIN_LEN;
  localparam int LIMIT = 40000;
  logic         sys_clk, reset_n, tck, tms, tdi, tdo, tdo_oe, snap_valid, snap_ready;
  logic         pin_drive_en, outputs_hiz, on_die_termination, normal_mode_lost;
  logic [W-1:0] pin_in, pin_drive, snap_data, sout, pv, prev;
  logic [W-1:0] snaps [$];
  logic [2:0]   codes [5] = '{3'h1, 3'h7, 3'h2, 3'h4, 3'h0};
  logic [2:0]   c;
  int           n_errors, tests_run, cycles, guard, oe_cycles;

  memory_boundary_scan_tap #(.CHAIN(W)) DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .pin_drive(pin_drive),
    .pin_drive_en(pin_drive_en), .outputs_hiz(outputs_hiz),
    .on_die_termination(on_die_termination), .normal_mode_lost(normal_mode_lost),
    .snap_valid(snap_valid), .snap_ready(snap_ready), .snap_data(snap_data));

  scan_tester tst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  // ----------------------------------------
  // Clock, timeout, report
  // ----------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (tdo_oe === 1'b1)
      oe_cycles <= oe_cycles + 1;
    if (cycles == LIMIT)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [W-1:0] rnd();
    return W'({$urandom(), $urandom(), $urandom(), $urandom()});
  endfunction

  task automatic load(input logic [2:0] code);
    tst.scan(1'b1, scan_tap_pkg::IR_WIDTH, W'(code), sout);
    chk(W'(sout[1:0]), W'(scan_tap_pkg::IR_CAPTURE[1:0]));
  endtask

  // Pins change only between frames, never inside a capture window
  task automatic set_pins();
    @(posedge sys_clk);
    #2 pin_in = rnd();
  endtask

  // Bench copy of the snapshot buffer: words beyond its depth are dropped
  task automatic push(input logic [W-1:0] v);
    if (snaps.size() < scan_tap_pkg::FIFO_DEPTH)
      snaps.push_back(v);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    reset_n = 1'b0;
    snap_ready = 1'b0;
    pin_in = '0;
    pv = '0;
    n_errors = 0;
    tests_run = 0;
    cycles = 0;
    guard = 0;
    void'($urandom(87));
    repeat (16) @(posedge sys_clk);
    #2 reset_n = 1'b1;
    tst.to_reset();
    foreach (codes[k])
    begin
      c = codes[k];
      prev = pv;
      load(c);
      chk(W'(tdo_oe), W'(1'b0));
      chk(W'(on_die_termination), W'(!(c inside {3'h0, 3'h2, 3'h4})));
      chk(W'(outputs_hiz), W'(c == 3'h2));
      chk(W'(pin_drive_en), W'(c == 3'h0));
      chk(W'(normal_mode_lost), W'(c == 3'h0));
      if (c == 3'h0)
        chk(pin_drive, prev);
      pv = rnd();
      if (c == 3'h1)
      begin
        oe_cycles = 0;
        tst.scan(1'b0, 32, pv, sout);
        chk(sout, W'(scan_tap_pkg::ID_VALUE));
        // Output driven for exactly 32 test clock periods of 8 system cycles
        chk(W'(oe_cycles), W'(32 * 8));
      end
      else if (c == 3'h7)
      begin
        tst.scan(1'b0, 9, pv, sout);
        chk(W'(sout[8:1]), W'(pv[7:0]));
      end
      else
      begin
        set_pins();
        tst.scan(1'b0, W, pv, sout);
        chk(sout, pin_in);
        push(pin_in);
        if (c == 3'h0)
          chk(pin_drive, pv);
      end
    end
    tst.to_reset();
    tst.scan(1'b0, 32, rnd(), sout);
    chk(sout, W'(scan_tap_pkg::ID_VALUE));
    chk(W'(normal_mode_lost), W'(1'b1));
    chk(W'(pin_drive_en), W'(1'b0));
    load(3'h4);
    repeat (34)
    begin
      set_pins();
      tst.capture();
      push(pin_in);
    end
    chk(W'(snap_valid), W'(1'b1));
    while (snaps.size() > 0 && guard < 5000)
    begin
      @(negedge sys_clk);
      if (snap_valid === 1'b1 && snap_ready === 1'b1)
        chk(snap_data, snaps.pop_front());
      @(posedge sys_clk);
      #2 snap_ready = 1'($urandom() % 2);
      guard++;
    end
    chk(W'(snaps.size()), '0);
    // Idle cycles stand in for the memory's clock recovery
    repeat (4) @(posedge sys_clk);
    #2 chk(W'(snap_valid), W'(1'b0));
    // Power-up again: leaves the EXTEST state behind
    @(posedge sys_clk);
    #2 reset_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #2 reset_n = 1'b1;
    chk(W'(normal_mode_lost), W'(1'b0));
    chk(W'(on_die_termination), W'(1'b1));
    chk(W'(pin_drive_en), W'(1'b0));
    chk(W'(snap_valid), W'(1'b0));
    tst.to_reset();
    tst.scan(1'b0, 32, rnd(), sout);
    chk(sout, W'(scan_tap_pkg::ID_VALUE));
    report_and_stop();
  end
endmodule // memory_boundary_scan_tap_tb
`default_nettype wire

// ### test/scan_tester.sv
// Board scan tester model driving the test pins of the memory port
`timescale 1ns/1ps
`default_nettype none
module scan_tester (
  // Test pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  localparam int HALF = 200;
  localparam int W    = scan_tap_pkg::CHAIN_LEN;

  // Clock parked low, mode and data pulled up between frames
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // tdo read late in the high phase, well after the falling-edge update
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #(HALF) tck = 1'b1;
    #(HALF - 10) q = tdo;
    #10 tck = 1'b0;
  endtask

  task automatic rest();
    #(HALF) tms = 1'b1;
    tdi = 1'b1;
    #(HALF);
  endtask

  task automatic to_reset();
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    rest();
  endtask

  // From idle through capture, n shifts, update and back to idle
  task automatic scan(input logic ir, input int n, input logic [W-1:0] din,
                      output logic [W-1:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b1, q);
    if (ir)
      step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    rest();
  endtask

  // Capture only: select, capture, exit, update, idle
  task automatic capture();
    logic q;
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b1, 1'b1, q);
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    rest();
  endtask
endmodule // scan_tester
`default_nettype wire
